// File: dv/hspc_board.sv
`timescale 1ns/1ps
`default_nettype none
module hspc_board (
   input wire logic [6:0] strap_dis_p,
   input wire logic [6:0] strap_dis_m,
   input wire logic [6:0] strap_swp,
   input wire logic strap_gang,
   input wire logic [6:0] fault,
   input wire logic [6:0] downstream_data_plus_o,
   input wire logic [6:0] downstream_data_plus_oe,
   input wire logic [6:0] downstream_data_minus_o,
   input wire logic [6:0] downstream_data_minus_oe,
   input wire logic [6:0] port_indicator_primary_low_o,
   input wire logic [6:0] port_indicator_primary_low_oe,
   input wire logic [6:0] port_indicator_enhanced_low_o,
   input wire logic [6:0] port_indicator_enhanced_low_oe,
   output logic [6:0] downstream_data_plus_i,
   output logic [6:0] downstream_data_minus_i,
   output logic [6:0] port_indicator_primary_low_i,
   output logic [6:0] port_indicator_enhanced_low_i,
   output logic [6:0] overcurrent_sense_low
);
   // ****************************************
   // strap resistors act as pulls once released
   // ****************************************
   wire logic [6:0] enh_pull = {4'hF, strap_gang, 2'h3};
   wire logic [6:0] dp_oe = downstream_data_plus_oe;
   wire logic [6:0] dm_oe = downstream_data_minus_oe;
   wire logic [6:0] pr_oe = port_indicator_primary_low_oe;
   wire logic [6:0] en_oe = port_indicator_enhanced_low_oe;
   assign downstream_data_plus_i = dp_oe & downstream_data_plus_o |
      ~dp_oe & strap_dis_p;
   assign downstream_data_minus_i = dm_oe & downstream_data_minus_o |
      ~dm_oe & strap_dis_m;
   assign port_indicator_primary_low_i = pr_oe &
      port_indicator_primary_low_o | ~pr_oe & strap_swp;
   assign port_indicator_enhanced_low_i = en_oe &
      port_indicator_enhanced_low_o | ~en_oe & enh_pull;
   // monitor pulls the sense line low while a fault lasts
   assign overcurrent_sense_low = ~fault;
endmodule // hspc_board
`default_nettype wire

// File: dv/hspc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module hspc_checker #(
   parameter int NPORT = 7
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   input wire logic upstream_power_detect,
   input wire logic upstream_pullup_enable,
   input wire logic [NPORT-1:0] core_plus_i,
   input wire logic [NPORT-1:0] downstream_data_plus_i,
   input wire logic [NPORT-1:0] downstream_data_minus_i,
   input wire logic [NPORT-1:0] downstream_data_plus_oe,
   input wire logic [NPORT-1:0] port_power_enable,
   input wire logic [NPORT-1:0] overcurrent_sense_low,
   input wire logic [NPORT-1:0] port_indicator_primary_low_i,
   input wire logic [NPORT-1:0] port_indicator_enhanced_low_i
);
   // ****************************************
   // own copy of the straps
   // ****************************************
   logic [1:0] cnt_q;
   logic [NPORT-1:0] dis_q;
   logic [NPORT-1:0] swp_q;
   logic gang_q;
   wire logic run = cnt_q == 2'h3;
   wire logic [NPORT-1:0] mux_p = (swp_q & downstream_data_minus_i |
      ~swp_q & downstream_data_plus_i) & ~dis_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 2'h0;
      end else begin
         cnt_q <= run ? cnt_q : cnt_q + 2'h1;
      end
   end
   // second edge after release is the capture edge
   always_ff @(posedge clk) begin
      if (cnt_q == 2'h1) begin
         dis_q <= downstream_data_plus_i & downstream_data_minus_i;
         swp_q <= port_indicator_primary_low_i;
         gang_q <= port_indicator_enhanced_low_i[2];
      end
   end
   // ****************************************
   // properties
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence s_vbus_gone;
      !upstream_power_detect [*4];
   endsequence
   sequence s_access;
      psel && !penable ##1 psel && penable;
   endsequence
   a_pullup_needs_vbus: assert property (
      s_vbus_gone |-> !upstream_pullup_enable)
      else $error("pull-up on without upstream power");
   a_dis_no_power: assert property (
      run |-> (port_power_enable & dis_q) == '0)
      else $error("disabled port powered");
   a_dis_no_drive: assert property (
      run |-> (downstream_data_plus_oe & dis_q) == '0)
      else $error("disabled port data driven");
   a_swap_data_path: assert property (
      run && $past(run) |-> core_plus_i == $past(mux_p))
      else $error("plus line not routed per swap");
   a_fault_cuts_power: assert property (
      run |-> (port_power_enable & ~$past(overcurrent_sense_low)) == '0)
      else $error("power kept on a faulting port");
   a_gang_all_none: assert property (
      run && gang_q |-> port_power_enable == '0
      || port_power_enable == ~dis_q)
      else $error("ganged ports switched apart");
   a_reset_quiet: assert property (
      $past(rst) |-> port_power_enable == '0
      && downstream_data_plus_oe == '0)
      else $error("outputs active at reset release");
   a_ready_second: assert property (s_access |-> !pready ##1 pready)
      else $error("answer not in second access cycle");
   a_err_with_ready: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error response outside answer");
endmodule // hspc_checker
bind hspc_top hspc_checker #(.NPORT(NPORT)) hspc_checker_i (.*);
`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, er;
   logic upstream_power_detect, upstream_pullup_enable, strap_gang;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [6:0] core_plus_o, core_minus_o, core_oe, core_plus_i;
   logic [6:0] core_minus_i, port_power_enable, overcurrent_sense_low;
   logic [6:0] downstream_data_plus_i, downstream_data_plus_o;
   logic [6:0] downstream_data_plus_oe, downstream_data_minus_i;
   logic [6:0] downstream_data_minus_o, downstream_data_minus_oe;
   logic [6:0] port_indicator_primary_low_i, port_indicator_primary_low_o;
   logic [6:0] port_indicator_primary_low_oe, port_indicator_enhanced_low_i;
   logic [6:0] port_indicator_enhanced_low_o, port_indicator_enhanced_low_oe;
   logic [6:0] strap_dis_p, strap_dis_m, strap_swp, fault;
   int mismatches = 0;
   int n_tests = 0;
   hspc_top hspc_top_i (.*);
   hspc_board hspc_board_i (.*);
   // ****************************************
   // shared tasks
   // ****************************************
   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
         mismatches++;
      end
   endtask
   task automatic chk7(input logic [6:0] g, input logic [6:0] e);
      chk({25'h0, g}, {25'h0, e});
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         mismatches++;
         complete_run();
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task automatic do_reset(input logic [6:0] p, input logic [6:0] m,
         input logic [6:0] s, input logic g);
      strap_dis_p <= p;
      strap_dis_m <= m;
      strap_swp <= s;
      strap_gang <= g;
      rst <= 1'b1;
      tick(4);
      rst <= 1'b0;
      tick(4);
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_straps();
      logic [6:0] dis;
      logic [6:0] cp;
      logic [31:0] e;
      dis = strap_dis_p & strap_dis_m;
      cp = (strap_swp & strap_dis_m | ~strap_swp & strap_dis_p) & ~dis;
      e = {14'h0, 1'b1, strap_gang, 1'b0, strap_swp, 1'b0, dis};
      rd_chk(hspc_pkg::OFS_STRAP, e);
      chk7(core_plus_i, cp);
      chk7(core_minus_i, (strap_swp & strap_dis_p | ~strap_swp
         & strap_dis_m) & ~dis);
      strap_dis_p <= ~strap_dis_p;
      strap_swp <= ~strap_swp;
      strap_gang <= ~strap_gang;
      apb(1'b1, hspc_pkg::OFS_STRAP, 32'hFFFFFFFF);
      rd_chk(hspc_pkg::OFS_STRAP, e);
      strap_dis_p <= ~strap_dis_p;
      strap_swp <= ~strap_swp;
      strap_gang <= ~strap_gang;
      apb(1'b0, 8'h1C, 32'h0);
      chk({31'h0, er}, 32'h1);
   endtask
   task automatic t_connect();
      upstream_power_detect <= 1'b0;
      apb(1'b1, hspc_pkg::OFS_CTRL, 32'h1);
      tick(6);
      chk({31'h0, upstream_pullup_enable}, 32'h0);
      upstream_power_detect <= 1'b1;
      tick(6);
      chk({31'h0, upstream_pullup_enable}, 32'h1);
      apb(1'b0, hspc_pkg::OFS_PINS, 32'h0);
      chk(rd & 32'h3, 32'h3);
   endtask
   task automatic t_leds();
      logic [6:0] m;
      logic [6:0] al;
      m = ~(strap_dis_p & strap_dis_m);
      al = 7'h7B | {4'h0, strap_gang, 2'h0};
      chk7(port_indicator_primary_low_oe, 7'h00);
      apb(1'b1, hspc_pkg::OFS_LED, 32'h3355);
      apb(1'b1, hspc_pkg::OFS_CTRL, 32'h3);
      tick(3);
      chk7(port_indicator_primary_low_oe & m, m);
      chk7(port_indicator_primary_low_o & m,
         (7'h55 ^ strap_swp) & m);
      chk7(port_indicator_enhanced_low_o & m, (7'h33 ^ al) & m);
      apb(1'b1, hspc_pkg::OFS_CTRL, 32'h1);
   endtask
   task automatic t_power();
      logic [6:0] m;
      m = ~(strap_dis_p & strap_dis_m);
      apb(1'b1, hspc_pkg::OFS_PWR, strap_gang ? 32'h1 : 32'h7F);
      tick(2);
      chk7(port_power_enable, m);
      fault <= 7'h11;
      tick(3);
      chk7(port_power_enable, strap_gang ? 7'h00 : m & 7'h6E);
      if (!strap_gang) begin
         apb(1'b0, hspc_pkg::OFS_STAT, 32'h0);
         chk(rd & 32'h7F, 32'h10);
         chk({31'h0, irq}, 32'h0);
         apb(1'b1, hspc_pkg::OFS_MASK, 32'h10);
         tick(2);
         chk({31'h0, irq}, 32'h1);
         fault <= 7'h00;
         tick(3);
         chk({31'h0, irq}, 32'h1);
         apb(1'b1, hspc_pkg::OFS_STAT, 32'h10);
         tick(2);
         chk({31'h0, irq}, 32'h0);
      end
      fault <= 7'h00;
      tick(3);
      chk7(port_power_enable, m);
   endtask
   // ****************************************
   // clock and main sequence
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {core_plus_o, core_minus_o, core_oe, fault} = '0;
      upstream_power_detect = 1'b1;
      rst = 1'b1;
      do_reset(7'h49, 7'h41, 7'h0A, 1'b0);
      t_straps();
      t_connect();
      t_leds();
      t_power();
      do_reset(7'h00, 7'h7F, 7'h35, 1'b1);
      t_straps();
      t_leds();
      t_power();
      complete_run();
   end
endmodule // testbench
`default_nettype wire

// File: hdl/hspc_led_drive.sv
`timescale 1ns/1ps
`default_nettype none
module hspc_led_drive #(
   parameter int W = 7
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic enable,
   input wire logic [W-1:0] lit,
   input wire logic [W-1:0] active_low,
   output logic [W-1:0] pin_o_q,
   output logic [W-1:0] pin_oe_q
);
   // ****************************************
   // polarity and drive
   // ****************************************
   // pin stays released until enabled so a strap can be read first
   wire logic [W-1:0] level_d;
   assign level_d = lit ^ active_low;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_o_q <= '0;
         pin_oe_q <= '0;
      end else begin
         pin_o_q <= level_d;
         pin_oe_q <= {W{enable}};
      end
   end
endmodule // hspc_led_drive
`default_nettype wire

// File: hdl/hspc_pkg.sv
package hspc_pkg;
   // ****************************************
   // geometry
   // ****************************************
   localparam int NPORT = 7;
   localparam int AW = 8;

   // ****************************************
   // register offsets (byte addresses)
   // ****************************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_PWR = 8'h04;
   localparam logic [7:0] OFS_LED = 8'h08;
   localparam logic [7:0] OFS_STRAP = 8'h0C;
   localparam logic [7:0] OFS_STAT = 8'h10;
   localparam logic [7:0] OFS_MASK = 8'h14;
   localparam logic [7:0] OFS_PINS = 8'h18;

   // ****************************************
   // field positions
   // ****************************************
   localparam int CTRL_CONN_BIT = 0;
   localparam int CTRL_LED_BIT = 1;
   localparam int ENH_LSB = 8;
   localparam int STRAP_GANG_BIT = 16;
   localparam int STRAP_DONE_BIT = 17;
   localparam int STAT_VBUS_BIT = 7;
   localparam int PINS_VBUS_BIT = 0;
   localparam int PINS_PULLUP_BIT = 1;
   localparam int STREN_DIS_BIT = 0;
   localparam int STREN_SWP_BIT = 1;
   localparam int STREN_GANG_BIT = 2;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam logic [6:0] PWR_RST = 7'h00;
   localparam logic [7:0] STAT_RST = 8'h00;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [2:0] STRAP_EN_ALL = 3'h7;

   // ****************************************
   // types
   // ****************************************
   typedef struct packed {
      logic [NPORT-1:0] dis;
      logic [NPORT-1:0] swp;
      logic gang;
   } hspc_strap_t;

   typedef enum logic [1:0] {
      HSPC_ST_RESET = 2'b00,
      HSPC_ST_SAMPLE = 2'b01,
      HSPC_ST_RUN = 2'b10
   } hspc_state_t;
endpackage

// File: hdl/hspc_strap_latch.sv
`timescale 1ns/1ps
`default_nettype none
module hspc_strap_latch #(
   parameter int W = 7
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic capture,
   input wire logic enable,
   input wire logic [W-1:0] pins,
   output logic [W-1:0] value_q
);
   // ****************************************
   // one-shot capture, held until next reset
   // ****************************************
   // a disabled strap reads as zero so the pin keeps its run-time job
   wire logic [W-1:0] value_d;
   assign value_d = capture ? (enable ? pins : '0) : value_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         value_q <= '0;
      end else begin
         value_q <= value_d;
      end
   end
endmodule // hspc_strap_latch
`default_nettype wire

// File: hdl/hspc_top.sv
// Functional notes
// - upstream power detect decides when the connect pull-up is enabled
// - a strap is sampled only when enabled; otherwise pin is run-time only
// - port disable strap: both data pins high at reset release disables
// - port power enables are active high only
// - swap strap: 1 swaps plus and minus of that port, 0 normal
// - primary LED active high for strap 0, active low for strap 1
// - primary LEDs of ports one to seven driven only when LEDs enabled
// - enhanced LEDs of ports four to seven active low when enabled
// - gang strap: 0 individual power and sensing, 1 ganged for all
// - port three enhanced LED: high in individual, low in ganged mode
// - names ending in low are asserted low except LED pins whose polarity a strap sets, all others high
`timescale 1ns/1ps
`default_nettype none
module hspc_top #(
   parameter int NPORT = hspc_pkg::NPORT,
   parameter logic [2:0] STRAP_EN = hspc_pkg::STRAP_EN_ALL
) (
   input wire logic clk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [hspc_pkg::AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   // upstream
   input wire logic upstream_power_detect,
   output logic upstream_pullup_enable,
   // hub core side of the downstream phys
   input wire logic [NPORT-1:0] core_plus_o,
   input wire logic [NPORT-1:0] core_minus_o,
   input wire logic [NPORT-1:0] core_oe,
   output logic [NPORT-1:0] core_plus_i,
   output logic [NPORT-1:0] core_minus_i,
   // downstream pins, shared with port disable straps
   input wire logic [NPORT-1:0] downstream_data_plus_i,
   output logic [NPORT-1:0] downstream_data_plus_o,
   output logic [NPORT-1:0] downstream_data_plus_oe,
   input wire logic [NPORT-1:0] downstream_data_minus_i,
   output logic [NPORT-1:0] downstream_data_minus_o,
   output logic [NPORT-1:0] downstream_data_minus_oe,
   // power switches and sensing
   output logic [NPORT-1:0] port_power_enable,
   input wire logic [NPORT-1:0] overcurrent_sense_low,
   // primary LEDs, shared with swap straps
   input wire logic [NPORT-1:0] port_indicator_primary_low_i,
   output logic [NPORT-1:0] port_indicator_primary_low_o,
   output logic [NPORT-1:0] port_indicator_primary_low_oe,
   // enhanced LEDs, port 3 shared with the gang strap
   input wire logic [NPORT-1:0] port_indicator_enhanced_low_i,
   output logic [NPORT-1:0] port_indicator_enhanced_low_o,
   output logic [NPORT-1:0] port_indicator_enhanced_low_oe
);
   // ****************************************
   // strap sequencing
   // ****************************************
   hspc_pkg::hspc_state_t state_q;
   hspc_pkg::hspc_state_t state_d;
   hspc_pkg::hspc_strap_t strap;
   wire logic capture;
   wire logic run;
   wire logic [NPORT-1:0] dis_pins;
   wire logic gang_pin;

   // first cycle after release lets pins settle, capture on the second
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         hspc_pkg::HSPC_ST_RESET: begin
            state_d = hspc_pkg::HSPC_ST_SAMPLE;
         end
         hspc_pkg::HSPC_ST_SAMPLE: begin
            state_d = hspc_pkg::HSPC_ST_RUN;
         end
         hspc_pkg::HSPC_ST_RUN: begin
            state_d = hspc_pkg::HSPC_ST_RUN;
         end
         default: begin
            state_d = hspc_pkg::HSPC_ST_RESET;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= hspc_pkg::HSPC_ST_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   assign capture = (state_q == hspc_pkg::HSPC_ST_SAMPLE);
   assign run = (state_q == hspc_pkg::HSPC_ST_RUN);
   // both lines pulled up marks a disabled port
   assign dis_pins = downstream_data_plus_i & downstream_data_minus_i;
   assign gang_pin = port_indicator_enhanced_low_i[2];

   hspc_strap_latch #(.W(NPORT)) u_dis (
      .clk(clk),
      .rst(rst),
      .capture(capture),
      .enable(STRAP_EN[hspc_pkg::STREN_DIS_BIT]),
      .pins(dis_pins),
      .value_q(strap.dis)
   );

   hspc_strap_latch #(.W(NPORT)) u_swp (
      .clk(clk),
      .rst(rst),
      .capture(capture),
      .enable(STRAP_EN[hspc_pkg::STREN_SWP_BIT]),
      .pins(port_indicator_primary_low_i),
      .value_q(strap.swp)
   );

   hspc_strap_latch #(.W(1)) u_gang (
      .clk(clk),
      .rst(rst),
      .capture(capture),
      .enable(STRAP_EN[hspc_pkg::STREN_GANG_BIT]),
      .pins(gang_pin),
      .value_q(strap.gang)
   );

   // ****************************************
   // control registers
   // ****************************************
   logic [1:0] ctrl_q;
   logic [NPORT-1:0] pwr_q;
   logic [NPORT-1:0] led_pri_q;
   logic [NPORT-1:0] led_enh_q;
   logic [7:0] stat_q;
   logic [7:0] mask_q;
   logic vbus_q;
   wire logic wr_go;
   wire logic rd_go;
   wire logic hit_ctrl;
   wire logic hit_pwr;
   wire logic hit_led;
   wire logic hit_strap;
   wire logic hit_stat;
   wire logic hit_mask;
   wire logic hit_pins;
   wire logic hit_any;

   function automatic logic hit(input logic [hspc_pkg::AW-1:0] a,
                                input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // access completes in the cycle that pready is high
   assign wr_go = psel & penable & pready & pwrite;
   assign rd_go = psel & penable & ~pready;
   assign hit_ctrl = hit(paddr, hspc_pkg::OFS_CTRL);
   assign hit_pwr = hit(paddr, hspc_pkg::OFS_PWR);
   assign hit_led = hit(paddr, hspc_pkg::OFS_LED);
   assign hit_strap = hit(paddr, hspc_pkg::OFS_STRAP);
   assign hit_stat = hit(paddr, hspc_pkg::OFS_STAT);
   assign hit_mask = hit(paddr, hspc_pkg::OFS_MASK);
   assign hit_pins = hit(paddr, hspc_pkg::OFS_PINS);
   assign hit_any = hit_ctrl | hit_pwr | hit_led | hit_strap | hit_stat
                    | hit_mask | hit_pins;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= hspc_pkg::CTRL_RST;
      end else if (wr_go && hit_ctrl) begin
         ctrl_q <= pwdata[1:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pwr_q <= hspc_pkg::PWR_RST;
      end else if (wr_go && hit_pwr) begin
         pwr_q <= pwdata[NPORT-1:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         led_pri_q <= '0;
         led_enh_q <= '0;
      end else if (wr_go && hit_led) begin
         led_pri_q <= pwdata[NPORT-1:0];
         led_enh_q <= pwdata[hspc_pkg::ENH_LSB +: NPORT];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mask_q <= hspc_pkg::MASK_RST;
      end else if (wr_go && hit_mask) begin
         mask_q <= pwdata[7:0];
      end
   end

   // ****************************************
   // port power and over-current
   // ****************************************
   wire logic [NPORT-1:0] oc_port;
   wire logic oc_any;
   wire logic [NPORT-1:0] oc_seen;
   wire logic [NPORT-1:0] req_eff;
   wire logic [NPORT-1:0] pwr_d;

   // fault is a low level on the sense input
   assign oc_port = ~overcurrent_sense_low & ~strap.dis;
   assign oc_any = |oc_port;
   // ganged mode: port 1 request and any fault govern every port
   assign oc_seen = strap.gang ? {NPORT{oc_any}} : oc_port;
   assign req_eff = strap.gang ? {NPORT{pwr_q[0]}} : pwr_q;
   // high switches the port on; disabled ports never power
   assign pwr_d = {NPORT{run}} & req_eff & ~strap.dis & ~oc_seen;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         port_power_enable <= '0;
      end else begin
         port_power_enable <= pwr_d;
      end
   end

   // ****************************************
   // upstream connect
   // ****************************************
   wire logic vbus_edge;
   wire logic pullup_d;

   assign vbus_edge = run & (upstream_power_detect ^ vbus_q);
   // connect only while upstream power is present
   assign pullup_d = run & ctrl_q[hspc_pkg::CTRL_CONN_BIT]
                     & upstream_power_detect;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         vbus_q <= 1'b0;
         upstream_pullup_enable <= 1'b0;
      end else begin
         vbus_q <= upstream_power_detect;
         upstream_pullup_enable <= pullup_d;
      end
   end

   // ****************************************
   // interrupt status
   // ****************************************
   wire logic [7:0] stat_set;
   wire logic [7:0] stat_clr;
   wire logic [7:0] stat_d;

   assign stat_set = {vbus_edge, oc_seen & {NPORT{run}}};
   assign stat_clr = (wr_go && hit_stat) ? pwdata[7:0] : 8'h00;
   // set beats a clear landing in the same cycle
   assign stat_d = (stat_q & ~stat_clr) | stat_set;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stat_q <= hspc_pkg::STAT_RST;
         irq <= 1'b0;
      end else begin
         stat_q <= stat_d;
         irq <= |(stat_d & mask_q);
      end
   end

   // ****************************************
   // downstream data pair swap
   // ****************************************
   wire logic [NPORT-1:0] dn_oe_d;
   wire logic [NPORT-1:0] dn_p_d;
   wire logic [NPORT-1:0] dn_m_d;
   wire logic [NPORT-1:0] up_p_d;
   wire logic [NPORT-1:0] up_m_d;

   // pins stay released until straps are held, and on disabled ports
   assign dn_oe_d = core_oe & ~strap.dis & {NPORT{run}};

   genvar gi;
   generate
      for (gi = 0; gi < NPORT; gi++) begin : g_swap
         assign dn_p_d[gi] = strap.swp[gi] ? core_minus_o[gi]
                                           : core_plus_o[gi];
         assign dn_m_d[gi] = strap.swp[gi] ? core_plus_o[gi]
                                           : core_minus_o[gi];
         assign up_p_d[gi] = strap.swp[gi] ? downstream_data_minus_i[gi]
                                           : downstream_data_plus_i[gi];
         assign up_m_d[gi] = strap.swp[gi] ? downstream_data_plus_i[gi]
                                           : downstream_data_minus_i[gi];
      end
   endgenerate

   // one register stage each way; the phy core sees one cycle of delay
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         downstream_data_plus_o <= '0;
         downstream_data_minus_o <= '0;
         downstream_data_plus_oe <= '0;
         downstream_data_minus_oe <= '0;
         core_plus_i <= '0;
         core_minus_i <= '0;
      end else begin
         downstream_data_plus_o <= dn_p_d;
         downstream_data_minus_o <= dn_m_d;
         downstream_data_plus_oe <= dn_oe_d;
         downstream_data_minus_oe <= dn_oe_d;
         core_plus_i <= up_p_d & ~strap.dis;
         core_minus_i <= up_m_d & ~strap.dis;
      end
   end

   // ****************************************
   // indicator LEDs
   // ****************************************
   wire logic led_on;
   wire logic [NPORT-1:0] pri_low;
   wire logic [NPORT-1:0] enh_low;

   assign led_on = run & ctrl_q[hspc_pkg::CTRL_LED_BIT];
   // with the swap strap off the primary LEDs are plain active low
   assign pri_low = STRAP_EN[hspc_pkg::STREN_SWP_BIT] ? strap.swp
                                                      : {NPORT{1'b1}};
   // port 3 enhanced follows the gang strap, the rest are active low
   assign enh_low = {{(NPORT-3){1'b1}},
                     STRAP_EN[hspc_pkg::STREN_GANG_BIT] ? strap.gang : 1'b1,
                     2'b11};

   hspc_led_drive #(.W(NPORT)) u_led_pri (
      .clk(clk),
      .rst(rst),
      .enable(led_on),
      .lit(led_pri_q),
      .active_low(pri_low),
      .pin_o_q(port_indicator_primary_low_o),
      .pin_oe_q(port_indicator_primary_low_oe)
   );

   hspc_led_drive #(.W(NPORT)) u_led_enh (
      .clk(clk),
      .rst(rst),
      .enable(led_on),
      .lit(led_enh_q),
      .active_low(enh_low),
      .pin_o_q(port_indicator_enhanced_low_o),
      .pin_oe_q(port_indicator_enhanced_low_oe)
   );

   // ****************************************
   // apb read and answer
   // ****************************************
   logic [31:0] rd_mux;

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_ctrl) begin
         rd_mux[1:0] = ctrl_q;
      end
      if (hit_pwr) begin
         rd_mux[NPORT-1:0] = pwr_q;
      end
      if (hit_led) begin
         rd_mux[NPORT-1:0] = led_pri_q;
         rd_mux[hspc_pkg::ENH_LSB +: NPORT] = led_enh_q;
      end
      if (hit_strap) begin
         rd_mux[NPORT-1:0] = strap.dis;
         rd_mux[hspc_pkg::ENH_LSB +: NPORT] = strap.swp;
         rd_mux[hspc_pkg::STRAP_GANG_BIT] = strap.gang;
         rd_mux[hspc_pkg::STRAP_DONE_BIT] = run;
      end
      if (hit_stat) begin
         rd_mux[7:0] = stat_q;
      end
      if (hit_mask) begin
         rd_mux[7:0] = mask_q;
      end
      if (hit_pins) begin
         rd_mux[hspc_pkg::PINS_VBUS_BIT] = vbus_q;
         rd_mux[hspc_pkg::PINS_PULLUP_BIT] = upstream_pullup_enable;
         rd_mux[hspc_pkg::ENH_LSB +: NPORT] = port_power_enable;
      end
   end

   // one wait state: pready rises in the second access cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= rd_go;
         pslverr <= rd_go & ~hit_any;
         prdata <= (rd_go && !pwrite) ? rd_mux : 32'h0000_0000;
      end
   end
endmodule // hspc_top
`default_nettype wire
